// ### hdl/motion_pkg.sv
// Constants, tables and types shared by the motion parameter decoder
package motion_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Register map
	localparam logic [7:0] OFS_MOTOR    = 8'h00;
	localparam logic [7:0] OFS_FALLBACK = 8'h04;
	localparam logic [7:0] OFS_STATUS   = 8'h08;

	// Motor register fields
	localparam int IRUN_LSB   = 0;
	localparam int IHOLD_LSB  = 4;
	localparam int VMAX_LSB   = 8;
	localparam int VMIN_LSB   = 12;
	localparam int ACC_LSB    = 16;
	localparam int SHAFT_BIT  = 20;
	localparam int USTEP_LSB  = 21;
	localparam int PERMIT_BIT = 23;
	localparam int CONT_BIT   = 24;
	localparam int MOTOR_W    = 25;
	localparam logic [MOTOR_W-1:0] MOTOR_RST = 25'h0000000;

	// Status register fields
	localparam int ST_COIL_LSB = 0;
	localparam int ST_PWM_BIT  = 10;
	localparam int ST_GND_BIT  = 11;
	localparam int ST_SLEEP_BIT = 12;
	localparam int ST_MOVE_BIT = 13;
	localparam int ST_POS_LSB  = 16;

	////////////////////////////////////////////////////////////////////////////////
	// Fallback target
	localparam int FALLBACK_W = 11;
	localparam int NVM_W      = 9;
	localparam int POS_W      = 16;
	localparam int POS_FILL_W = POS_W - FALLBACK_W;
	localparam logic [NVM_W-1:0]      FALLBACK_OFF = 9'h100;
	localparam logic [FALLBACK_W-1:0] FALLBACK_RST = 11'h400;

	////////////////////////////////////////////////////////////////////////////////
	// Current ladder in mA, speeds in full steps/s, ramps in full steps/s^2
	localparam logic [3:0] HOLD_OFF_CODE = 4'hf;
	localparam logic [3:0] LOWEST_CODE   = 4'h0;
	localparam logic [9:0] CURRENT_MA [16] = '{10'h03b, 10'h047, 10'h054, 10'h064, 10'h077, 10'h08d,
		10'h0a8, 10'h0c8, 10'h0ee, 10'h11b, 10'h150, 10'h190, 10'h1dc, 10'h236, 10'h2a1, 10'h320};
	localparam logic [9:0] VMAX_FSPS [16] = '{10'h063, 10'h088, 10'h0a7, 10'h0c5, 10'h0d5, 10'h0e4,
		10'h0f3, 10'h111, 10'h12f, 10'h14e, 10'h16c, 10'h18b, 10'h1c8, 10'h222, 10'h2d9, 10'h3cd};
	localparam logic [15:0] ACC_RATE [16] = '{16'h0031, 16'h00da, 16'h03ec, 16'h0e19, 16'h1854, 16'h2290,
		16'h2c91, 16'h3692, 16'h4093, 16'h4a94, 16'h557e, 16'h5f7f, 16'h6980, 16'h7382, 16'h886d, 16'h9c6f};
	localparam logic [3:0] VMIN_FULL  = 4'h0;
	localparam int         VMIN_SHIFT = 5;

	////////////////////////////////////////////////////////////////////////////////
	// Timing
	localparam int CLK_PERIOD_NS = 100;
	localparam int DROP_TIME_NS  = 100_000;
	localparam int DROP_CYCLES   = (DROP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	typedef enum logic [1:0] {
		HS_RUN  = 2'b00,
		HS_HOLD = 2'b01,
		HS_DROP = 2'b10,
		HS_OFF  = 2'b11
	} hold_state_e;

	function automatic logic [9:0] current_ma(input logic [3:0] code);
		return CURRENT_MA[code];
	endfunction

	function automatic logic [4:0] ustep_div(input logic [1:0] code);
		return 5'h02 << code;
	endfunction

endpackage

// ### hdl/hold_current_seq.sv
// Coil current sequencer: run, hold and the staged switch-off
`timescale 1ns/10ps
`default_nettype none

module hold_current_seq #(
	parameter int DROP_CYCLES = motion_pkg::DROP_CYCLES
) (
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       motion_active,
	input  wire logic [3:0] irun,
	input  wire logic [3:0] ihold,
	output logic      [9:0] coil_ma_r,
	output logic            pwm_en_r,
	output logic            gnd_r
);
	// The dwell counter is 16 bits wide
	if (DROP_CYCLES < 1 || DROP_CYCLES > 65535) begin
		$error("DROP_CYCLES out of range");
	end

	motion_pkg::hold_state_e state_r;
	motion_pkg::hold_state_e state_nxt;
	logic [15:0]             drop_cnt_r;

	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			motion_pkg::HS_RUN: begin
				if (!motion_active)
					state_nxt = (ihold == motion_pkg::HOLD_OFF_CODE) ? motion_pkg::HS_DROP : motion_pkg::HS_HOLD;
			end
			motion_pkg::HS_HOLD: begin
				if (motion_active)
					state_nxt = motion_pkg::HS_RUN;
				else if (ihold == motion_pkg::HOLD_OFF_CODE)
					state_nxt = motion_pkg::HS_DROP;
			end
			motion_pkg::HS_DROP: begin
				if (motion_active)
					state_nxt = motion_pkg::HS_RUN;
				else if (drop_cnt_r == 16'(DROP_CYCLES - 1))
					state_nxt = motion_pkg::HS_OFF;
			end
			motion_pkg::HS_OFF: begin
				if (motion_active)
					state_nxt = motion_pkg::HS_RUN;
				else if (ihold != motion_pkg::HOLD_OFF_CODE)
					state_nxt = motion_pkg::HS_HOLD;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r    <= motion_pkg::HS_RUN;
			drop_cnt_r <= 16'h0000;
		end else begin
			state_r    <= state_nxt;
			drop_cnt_r <= (state_nxt == motion_pkg::HS_DROP && state_r == motion_pkg::HS_DROP) ?
				drop_cnt_r + 16'h0001 : 16'h0000;
		end
	end

	// Outputs follow the next state so they align with the state register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			coil_ma_r <= 10'h000;
			pwm_en_r  <= 1'b0;
			gnd_r     <= 1'b0;
		end else begin
			unique case (state_nxt)
				motion_pkg::HS_RUN:  coil_ma_r <= motion_pkg::current_ma(irun);
				motion_pkg::HS_HOLD: coil_ma_r <= motion_pkg::current_ma(ihold);
				motion_pkg::HS_DROP: coil_ma_r <= motion_pkg::current_ma(motion_pkg::LOWEST_CODE);
				motion_pkg::HS_OFF:  coil_ma_r <= 10'h000;
			endcase
			pwm_en_r <= (state_nxt != motion_pkg::HS_OFF);
			gnd_r    <= (state_nxt == motion_pkg::HS_OFF);
		end
	end

endmodule

`default_nettype wire

// ### hdl/speed_decode.sv
// Speed and ramp code decoding
`timescale 1ns/10ps
`default_nettype none

module speed_decode (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic [3:0]  vmax_code,
	input  wire logic [3:0]  vmin_code,
	input  wire logic [3:0]  acc_code,
	output logic      [9:0]  vmax_r,
	output logic      [9:0]  vmin_r,
	output logic      [15:0] ramp_r
);
	logic [9:0]  vmax_sel;
	logic [13:0] vmin_prod;

	assign vmax_sel  = motion_pkg::VMAX_FSPS[vmax_code];
	assign vmin_prod = vmax_sel * vmin_code;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			vmax_r <= 10'h000;
			vmin_r <= 10'h000;
			ramp_r <= 16'h0000;
		end else begin
			vmax_r <= vmax_sel;
			vmin_r <= (vmin_code == motion_pkg::VMIN_FULL) ? vmax_sel :
				10'(vmin_prod >> motion_pkg::VMIN_SHIFT);
			ramp_r <= motion_pkg::ACC_RATE[acc_code];
		end
	end

endmodule

`default_nettype wire

// ### hdl/motion_parameter_decode.sv
// Motion parameter decoder top: APB registers, fallback target, sleep decisions
`timescale 1ns/10ps
`default_nettype none

module motion_parameter_decode #(
	parameter int ADDR_W      = 8,
	parameter int DROP_CYCLES = motion_pkg::DROP_CYCLES
) (
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire logic              motion_active,
	input  wire logic [15:0]       act_pos,
	input  wire logic              bus_lost,
	input  wire logic              err_overflow,
	input  wire logic              bus_timeout,
	input  wire logic              sleep_cmd,
	input  wire logic              standby_or_shutdown,
	input  wire logic              failure_present,
	input  wire logic              wake,
	input  wire logic              nvm_load,
	input  wire logic [8:0]        nvm_fallback,
	output logic      [9:0]        coil_current_ma,
	output logic                   pwm_enable,
	output logic                   low_side_ground,
	output logic      [4:0]        microstep_div,
	output logic                   dir_cw,
	output logic      [15:0]       ramp_rate,
	output logic      [9:0]        vmax_fsps,
	output logic      [9:0]        vmin_fsps,
	output logic                   fallback_go,
	output logic      [15:0]       fallback_pos,
	output logic                   sleep_req,
	output logic                   stop_req
);
	// The status offset needs four address bits
	if (ADDR_W < 4 || ADDR_W > 32) begin
		$error("ADDR_W out of range");
	end

	////////////////////////////////////////////////////////////////////////////////
	// Register storage and field views
	logic [motion_pkg::MOTOR_W-1:0]    motor_r;
	logic [motion_pkg::FALLBACK_W-1:0] fallback_r;
	logic [3:0]                        irun;
	logic [3:0]                        ihold;
	logic [1:0]                        microstep_resolution;
	logic                              auto_sleep_permit;
	logic                              continuous_speed_mode;
	logic                              shaft;
	logic                              fallback_off;
	logic                              apb_access;
	logic                              apb_done;
	logic                              ofs_hit;

	assign irun                  = motor_r[motion_pkg::IRUN_LSB +: 4];
	assign ihold                 = motor_r[motion_pkg::IHOLD_LSB +: 4];
	assign microstep_resolution  = motor_r[motion_pkg::USTEP_LSB +: 2];
	assign auto_sleep_permit     = motor_r[motion_pkg::PERMIT_BIT];
	assign continuous_speed_mode = motor_r[motion_pkg::CONT_BIT];
	assign shaft                 = motor_r[motion_pkg::SHAFT_BIT];
	assign fallback_off = (fallback_r[motion_pkg::FALLBACK_W-1:2] == motion_pkg::FALLBACK_OFF);

	////////////////////////////////////////////////////////////////////////////////
	// APB slave: one wait state, write lands on the edge that sees pready high
	assign apb_access = psel && penable;
	assign apb_done   = apb_access && pready;
	// Status is read-only: a write to it is dropped and raises no error

	function automatic logic reg_hit(input logic [7:0] ofs, input logic [ADDR_W-1:0] addr);
		return (ADDR_W > 8) ? (addr == ADDR_W'(ofs)) : (ofs == 8'(addr));
	endfunction

	assign ofs_hit = reg_hit(motion_pkg::OFS_MOTOR, paddr) || reg_hit(motion_pkg::OFS_FALLBACK, paddr) ||
		reg_hit(motion_pkg::OFS_STATUS, paddr);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h00000000;
		end else begin
			pready  <= apb_access && !pready;
			pslverr <= apb_access && !pready && !ofs_hit;
			if (apb_access && !pready && !pwrite) begin
				prdata <= 32'h00000000;
				if (reg_hit(motion_pkg::OFS_MOTOR, paddr))
					prdata <= 32'(motor_r);
				else if (reg_hit(motion_pkg::OFS_FALLBACK, paddr))
					prdata <= 32'(fallback_r);
				else if (reg_hit(motion_pkg::OFS_STATUS, paddr)) begin
					prdata[motion_pkg::ST_COIL_LSB +: 10] <= coil_current_ma;
					prdata[motion_pkg::ST_PWM_BIT]        <= pwm_enable;
					prdata[motion_pkg::ST_GND_BIT]        <= low_side_ground;
					prdata[motion_pkg::ST_SLEEP_BIT]      <= sleep_req;
					prdata[motion_pkg::ST_MOVE_BIT]       <= motion_active;
					prdata[motion_pkg::ST_POS_LSB +: 16]  <= fallback_pos;
				end
			end else if (!apb_access) begin
				prdata <= 32'h00000000;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			motor_r <= motion_pkg::MOTOR_RST;
		else if (apb_done && pwrite && reg_hit(motion_pkg::OFS_MOTOR, paddr))
			motor_r <= pwdata[motion_pkg::MOTOR_W-1:0];
	end

	// The nonvolatile load wins over a bus write in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			fallback_r <= motion_pkg::FALLBACK_RST;
		else if (nvm_load)
			fallback_r <= {nvm_fallback, 2'b00};
		else if (apb_done && pwrite && reg_hit(motion_pkg::OFS_FALLBACK, paddr))
			fallback_r <= pwdata[motion_pkg::FALLBACK_W-1:0];
	end

	////////////////////////////////////////////////////////////////////////////////
	// Coil current and speed decoding
	hold_current_seq #(
		.DROP_CYCLES (DROP_CYCLES)
	) u_hold (
		.pclk          (pclk),
		.presetn       (presetn),
		.motion_active (motion_active),
		.irun          (irun),
		.ihold         (ihold),
		.coil_ma_r     (coil_current_ma),
		.pwm_en_r      (pwm_enable),
		.gnd_r         (low_side_ground)
	);

	speed_decode u_speed (
		.pclk      (pclk),
		.presetn   (presetn),
		.vmax_code (motor_r[motion_pkg::VMAX_LSB +: 4]),
		.vmin_code (motor_r[motion_pkg::VMIN_LSB +: 4]),
		.acc_code  (motor_r[motion_pkg::ACC_LSB +: 4]),
		.vmax_r    (vmax_fsps),
		.vmin_r    (vmin_fsps),
		.ramp_r    (ramp_rate)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Step resolution and direction
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			microstep_div <= 5'h02;
		else
			microstep_div <= motion_pkg::ustep_div(microstep_resolution);
	end

	// Direction freezes in continuous-speed mode rather than following the bit
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			dir_cw <= 1'b0;
		else if (!continuous_speed_mode)
			dir_cw <= shaft;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Fallback target on bus loss or error overflow
	// Position is only loaded on an event, so it stands until the next one
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fallback_go  <= 1'b0;
			fallback_pos <= 16'h0000;
		end else begin
			fallback_go <= bus_lost || err_overflow;
			if (bus_lost || err_overflow) begin
				if (fallback_off)
					fallback_pos <= act_pos;
				else
					fallback_pos <= {fallback_r, {motion_pkg::POS_FILL_W{1'b0}}};
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Sleep and stop decisions; a sleep cause in the wake cycle still sleeps
	logic sleep_set;
	logic stop_set;

	assign sleep_set = (bus_timeout && (auto_sleep_permit || standby_or_shutdown)) ||
		(sleep_cmd && auto_sleep_permit);
	assign stop_set = (bus_timeout && !auto_sleep_permit && !standby_or_shutdown && !failure_present) ||
		(sleep_cmd && !auto_sleep_permit);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			sleep_req <= 1'b0;
		else if (sleep_set)
			sleep_req <= 1'b1;
		else if (wake)
			sleep_req <= 1'b0;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			stop_req <= 1'b0;
		else
			stop_req <= stop_set;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence hold_stop_s;
		$fell(motion_active) && ihold != motion_pkg::HOLD_OFF_CODE;
	endsequence

	sequence off_stop_s;
		$fell(motion_active) && ihold == motion_pkg::HOLD_OFF_CODE;
	endsequence

	sequence drop_level_s;
		coil_current_ma == motion_pkg::current_ma(motion_pkg::LOWEST_CODE) && pwm_enable && !low_side_ground;
	endsequence

	// Current sequence
	a_hold_lowered:
	assert property (hold_stop_s |=> coil_current_ma == motion_pkg::current_ma($past(ihold)))
		else $error("hold current not applied at standstill");
	a_drop_first:
	assert property (off_stop_s |=> drop_level_s) else $error("zero hold did not start at lowest level");
	a_off_after_drop:
	assert property ($rose(low_side_ground) |-> !pwm_enable && coil_current_ma == 10'h000 &&
		$past(coil_current_ma) == motion_pkg::current_ma(motion_pkg::LOWEST_CODE))
		else $error("bridges grounded without lowest level first");
	// Hold ladder excludes zero, so the regulator stays on for every code below 1111
	a_hold_nonzero:
	assert property (hold_stop_s |=> coil_current_ma != 10'h000 && pwm_enable && !low_side_ground)
		else $error("hold level left the ladder");
	a_ustep_div:
	assert property ($changed(microstep_resolution) |=> microstep_div == (5'h02 << $past(microstep_resolution)))
		else $error("microstep divider wrong");
	a_dir_frozen:
	assert property (continuous_speed_mode && $past(continuous_speed_mode) |-> $stable(dir_cw))
		else $error("direction moved in continuous mode");
	a_dir_follow:
	assert property (!continuous_speed_mode |=> dir_cw == $past(shaft))
		else $error("direction did not follow the bit");
	// Fallback target
	a_fallback_go:
	assert property ((bus_lost || err_overflow) && !fallback_off |=> fallback_go &&
		fallback_pos == {$past(fallback_r), {motion_pkg::POS_FILL_W{1'b0}}})
		else $error("fallback target not issued");
	a_overflow_go:
	assert property (err_overflow |=> fallback_go) else $error("overflow did not issue fallback");
	a_fallback_hold:
	assert property ((bus_lost || err_overflow) && fallback_off |=> fallback_go && fallback_pos == $past(act_pos))
		else $error("disabled fallback did not hold position");
	a_fallback_fill:
	assert property (fallback_go && !$past(fallback_off) |-> fallback_pos[motion_pkg::POS_FILL_W-1:0] == '0)
		else $error("fallback low bits not zero");
	a_nvm_pack:
	assert property (nvm_load |=> fallback_r[1:0] == 2'b00 && fallback_r[10:2] == $past(nvm_fallback))
		else $error("nonvolatile fallback packed wrong");
	// Sleep and stop
	a_timeout_sleep:
	assert property (bus_timeout && auto_sleep_permit |=> sleep_req) else $error("timeout did not sleep");
	a_no_auto_sleep:
	assert property (bus_timeout && !auto_sleep_permit && !standby_or_shutdown && !sleep_cmd && !failure_present
		|=> !$rose(sleep_req) && stop_req) else $error("timeout slept without permit");
	a_standby_sleep:
	assert property (bus_timeout && standby_or_shutdown |=> sleep_req) else $error("standby timeout did not sleep");
	a_cmd_sleep:
	assert property (sleep_cmd && auto_sleep_permit |=> sleep_req && !stop_req)
		else $error("sleep command with permit did not sleep");
	a_cmd_stop:
	assert property (sleep_cmd && !auto_sleep_permit && !bus_timeout |=> stop_req && !$rose(sleep_req))
		else $error("sleep command without permit did not stop");
	// A sleep cause in the same cycle as wake keeps the request set
	a_wake_clear:
	assert property (wake && !bus_timeout && !sleep_cmd |=> !sleep_req) else $error("wake did not clear sleep");
	a_stop_pulse:
	assert property (stop_req && !bus_timeout && !sleep_cmd |=> !stop_req)
		else $error("stop request held too long");
	// Decode and bus
	a_ramp_table:
	assert property ($changed(motor_r[motion_pkg::ACC_LSB +: 4]) |=> ramp_rate ==
		motion_pkg::ACC_RATE[$past(motor_r[motion_pkg::ACC_LSB +: 4])]) else $error("ramp rate wrong");
	a_vmax_table:
	assert property ($changed(motor_r[motion_pkg::VMAX_LSB +: 4]) |=>
		vmax_fsps == motion_pkg::VMAX_FSPS[$past(motor_r[motion_pkg::VMAX_LSB +: 4])])
		else $error("maximum speed wrong");
	a_vmin_full:
	assert property (motor_r[motion_pkg::VMIN_LSB +: 4] == motion_pkg::VMIN_FULL && $stable(motor_r)
		|=> vmin_fsps == vmax_fsps) else $error("minimum speed factor one broken");
	a_apb_wait: assert property (apb_access && !pready |=> pready && $past(psel)) else $error("APB answer late");

endmodule

`default_nettype wire

// ### testbench/motor_side_model.sv
// Motor side stand-in: moves while commanded and reports the position it reached
`timescale 1ns/10ps
`default_nettype none

module motor_side_model (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        move,
	output logic             motion_active,
	output logic      [15:0] act_pos
);
	////////////////////////////////////////////////////////////////////////////////
	// Position only advances in motion, so a stop freezes the value an event must keep
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			motion_active <= 1'b0;
			act_pos       <= 16'h1230;
		end else begin
			motion_active <= move;
			if (move) begin
				act_pos <= act_pos + 16'h0003;
			end
		end
	end
endmodule
`default_nettype wire

// ### testbench/tb_motion_parameter_decode.sv
// Self-checking bench for the motion parameter decoder over APB
`timescale 1ns/10ps
`default_nettype none

`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin errors++; \
	$display("[FAIL] %0t got %h exp %h", $time, (a), (b)); end end

module tb_motion_parameter_decode;
	localparam int DROP = 4;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, move = 1'b0;
	logic stby = 1'b0, fail = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, er, motion_active, pwm_enable, low_side_ground, dir_cw, fallback_go, sleep_req;
	logic stop_req;
	logic [15:0] act_pos, ramp_rate, fallback_pos;
	logic [9:0] coil_current_ma, vmax_fsps, vmin_fsps;
	logic [4:0] microstep_div;
	logic [5:0] ev = 6'h00;
	logic [8:0] nvm = 9'h000;
	int errors = 0, cmp_count = 0;

	always #50 pclk = ~pclk;

	motor_side_model motor_u (.pclk(pclk), .presetn(presetn), .move(move), .motion_active(motion_active),
		.act_pos(act_pos));
	motion_parameter_decode #(.DROP_CYCLES(DROP)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .motion_active(motion_active), .act_pos(act_pos), .bus_lost(ev[0]),
		.err_overflow(ev[1]), .bus_timeout(ev[2]), .sleep_cmd(ev[3]), .standby_or_shutdown(stby),
		.failure_present(fail), .wake(ev[4]), .nvm_load(ev[5]), .nvm_fallback(nvm),
		.coil_current_ma(coil_current_ma), .pwm_enable(pwm_enable), .low_side_ground(low_side_ground),
		.microstep_div(microstep_div), .dir_cw(dir_cw), .ramp_rate(ramp_rate), .vmax_fsps(vmax_fsps),
		.vmin_fsps(vmin_fsps), .fallback_go(fallback_go), .fallback_pos(fallback_pos),
		.sleep_req(sleep_req), .stop_req(stop_req));

	////////////////////////////////////////////////////////////////////////////////
	task automatic tick(input int n);
		repeat (n) @(posedge pclk);
	endtask

	// Waits as long as the slave needs; only the watchdog ends a hang
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0; penable <= 1'b0;
	endtask

	// Motor word, then two edges so the registered decode has landed
	task automatic motor(input logic [3:0] ir, ih, vx, vn, ac, input logic sh, input logic [1:0] us,
		input logic pm, ct);
		apb(1'b1, 8'h00, {7'h00, ct, pm, us, sh, ac, vn, vx, ih, ir});
		tick(2);
	endtask

	// Event pulse of one cycle; outputs are looked at just after the edge that answers it
	task automatic pulse(input int i);
		@(posedge pclk);
		ev[i] <= 1'b1;
		@(posedge pclk);
		ev <= 6'h00;
		#1;
	endtask

	task automatic complete_run;
		$display("errors=%0d comparisons=%0d", errors, cmp_count);
		if (errors == 0 && cmp_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	initial begin
		tick(30000);
		errors++;
		complete_run;
	end

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		tick(2);
		presetn <= 1'b1;
		apb(1'b0, 8'h00, 32'h0);
		`CHK(rd, 32'h0)
		apb(1'b0, 8'h04, 32'h0);
		`CHK(rd, 32'h400)
		apb(1'b0, 8'h08, 32'h0);
		`CHK(rd[11:0], 12'h43b)
		apb(1'b1, 8'h0c, 32'hffff_ffff);
		`CHK(er, 1'b1)
		`CHK(rd, 32'h0)
		// Run at code 4'he, one below the top code, then hold at code 3
		motor(4'he, 4'h3, 4'hf, 4'h7, 4'h0, 1'b1, 2'b00, 1'b1, 1'b0);
		`CHK(vmax_fsps, 10'd973)
		`CHK(vmin_fsps, 10'd212)
		`CHK(ramp_rate, 16'd49)
		`CHK(dir_cw, 1'b1)
		move <= 1'b1;
		tick(3);
		`CHK(coil_current_ma, 10'd673)
		move <= 1'b0;
		tick(3);
		`CHK(coil_current_ma, 10'd100)
		// Switch-off code: lowest level first, bridges grounded later
		motor(4'he, 4'hf, 4'h0, 4'h0, 4'hf, 1'b0, 2'b00, 1'b1, 1'b1);
		`CHK(vmax_fsps, 10'd99)
		`CHK(vmin_fsps, 10'd99)
		`CHK(ramp_rate, 16'd40047)
		`CHK(dir_cw, 1'b1)
		move <= 1'b1;
		tick(3);
		move <= 1'b0;
		tick(3);
		`CHK(coil_current_ma, 10'd59)
		`CHK(pwm_enable, 1'b1)
		tick(DROP - 2);
		#1;
		`CHK(coil_current_ma, 10'd59)
		tick(1);
		#1;
		`CHK(coil_current_ma, 10'd0)
		`CHK({pwm_enable, low_side_ground}, 2'b01)
		for (int us = 0; us < 4; us++) begin
			motor(4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 1'b0, us[1:0], 1'b1, 1'b0);
			`CHK(microstep_div, 5'h02 << us)
		end
		`CHK(dir_cw, 1'b0)
		////////////////////////////////////////////////////////////////////////////////
		apb(1'b1, 8'h04, 32'h155);
		pulse(0);
		`CHK({fallback_go, fallback_pos}, {1'b1, 11'h155, 5'h00})
		tick(1);
		#1;
		`CHK(fallback_go, 1'b0)
		apb(1'b1, 8'h04, 32'h7ff);
		pulse(1);
		`CHK({fallback_go, fallback_pos}, {1'b1, 16'hffe0})
		apb(1'b1, 8'h04, 32'h401);
		pulse(0);
		`CHK({fallback_go, fallback_pos}, {1'b1, act_pos})
		nvm <= 9'h1ab;
		pulse(5);
		apb(1'b0, 8'h04, 32'h0);
		`CHK(rd, 32'h6ac)
		////////////////////////////////////////////////////////////////////////////////
		pulse(2);
		`CHK(sleep_req, 1'b1)
		pulse(4);
		`CHK(sleep_req, 1'b0)
		pulse(3);
		`CHK({sleep_req, stop_req}, 2'b10)
		pulse(4);
		motor(4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 1'b0, 2'b00, 1'b0, 1'b0);
		pulse(2);
		`CHK({sleep_req, stop_req}, 2'b01)
		fail <= 1'b1;
		pulse(2);
		`CHK({sleep_req, stop_req}, 2'b00)
		fail <= 1'b0;
		pulse(3);
		`CHK({sleep_req, stop_req}, 2'b01)
		stby <= 1'b1;
		pulse(2);
		`CHK(sleep_req, 1'b1)
		complete_run;
	end
endmodule
`default_nettype wire
